/* core/efa_pkg.sv */
// Package for the external fault annunciator: register map, fields, types.
// Assumes a 32-bit APB slave on a single 10 MHz clock.
package efa_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] EFA_OFF_HEAVY_CODE  = 8'h00;
    localparam logic [7:0] EFA_OFF_LIGHT_CODE  = 8'h04;
    localparam logic [7:0] EFA_OFF_CHECK       = 8'h08;
    localparam logic [7:0] EFA_OFF_SUM_ERR     = 8'h0c;
    localparam logic [7:0] EFA_OFF_SUM_WARN    = 8'h10;
    localparam logic [7:0] EFA_OFF_SCAN_END    = 8'h14;
    localparam logic [7:0] EFA_OFF_INDICATORS  = 8'h18;
    localparam logic [7:0] EFA_OFF_IRQ_STATUS  = 8'h1c;
    localparam logic [7:0] EFA_OFF_IRQ_MASK    = 8'h20;
    localparam logic [7:0] EFA_OFF_LIGHT_ALIAS = 8'h24;
    // ==========================================================
    // Field positions
    localparam int EFA_BIT_HEAVY_CHK = 0;
    localparam int EFA_BIT_LIGHT_CHK = 1;
    localparam int EFA_BIT_ANNUNCIATOR_ERROR_BIT  = 0;
    localparam int EFA_BIT_ANNUNCIATOR_WARNING_BIT = 0;
    localparam int EFA_BIT_IRQ_HEAVY = 0;
    localparam int EFA_BIT_IRQ_LIGHT = 1;
    // ==========================================================
    // Reset values
    localparam logic [31:0] EFA_RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  EFA_RST_BITS = 2'h0;
    // ==========================================================
    // Indicator bundle
    typedef struct packed {
        logic error_indicator;
        logic supply_status_indicator;
        logic check_indicator;
    } efa_leds_t;

    typedef enum logic [1:0] {
        EFA_RUN,
        EFA_HALT
    } efa_state_t;
endpackage

/* core/efa_word_reg.sv */
// Small register bank for the two fault code words.
// Assumes one clock and asynchronous active-high reset.
`timescale 1ns/1ns
module efa_word_reg
    import efa_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Write port
    input  wire logic             wr_en,
    input  wire logic             wr_sel,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port, registered
    input  wire logic             rd_sel,
    output logic      [WIDTH-1:0] rd_data,
    // Live values
    output logic      [WIDTH-1:0] word0,
    output logic      [WIDTH-1:0] word1
);
    // ==========================================================
    // Storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            word0 <= WIDTH'(EFA_RST_WORD);
            word1 <= WIDTH'(EFA_RST_WORD);
        end else if (wr_en && !wr_sel) begin
            word0 <= wr_data;
        end else if (wr_en && wr_sel) begin
            word1 <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= WIDTH'(EFA_RST_WORD);
        end else begin
            rd_data <= rd_sel ? word1 : word0;
        end
    end
endmodule

/* core/efa_annunciator.sv */
// External fault annunciator: evaluates fault code words at scan end.
// Assumes an APB master on clk and a one-cycle scan_end pulse or register.
//
// Overview of operation
// RULE_01: Heavy faults halt; light faults only warn.
// RULE_02: Heavy word evaluated at scan end when requested.
// RULE_03: Heavy fault sets annunciator error bit.
// RULE_04: Heavy fault forces outputs off, holds error state.
// RULE_05: Heavy fault lights error, supply, check indicators.
// RULE_06: Heavy indicators latch until controller reset.
// RULE_07: Heavy code word stays readable.
// RULE_08: Light word evaluated at scan end when requested.
// RULE_09: Light fault sets warning bit, supply, check.
// RULE_10: Clearing light request clears warning and indicators.
// RULE_11: Light code word stays directly readable.
// RULE_12: Zero code means no fault; nonzero faults.
`timescale 1ns/1ns
module efa_annunciator
    import efa_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Scan completion from the sequencer
    input  wire logic        scan_end,
    // Plant side
    output logic             outputs_off,
    output logic             halted,
    output efa_leds_t        leds,
    // Interrupt
    output logic             irq
);
    // ==========================================================
    // Bus decode
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire rd       = acc && !pwrite;
    wire hit_hc   = paddr == EFA_OFF_HEAVY_CODE;
    wire hit_lc   = paddr == EFA_OFF_LIGHT_CODE;
    wire hit_la   = paddr == EFA_OFF_LIGHT_ALIAS;
    wire hit_chk  = paddr == EFA_OFF_CHECK;
    wire hit_se   = paddr == EFA_OFF_SUM_ERR;
    wire hit_sw   = paddr == EFA_OFF_SUM_WARN;
    wire hit_scan = paddr == EFA_OFF_SCAN_END;
    wire hit_led  = paddr == EFA_OFF_INDICATORS;
    wire hit_ist  = paddr == EFA_OFF_IRQ_STATUS;
    wire hit_msk  = paddr == EFA_OFF_IRQ_MASK;
    wire hit_code = hit_hc || hit_lc || hit_la;
    wire mapped   = hit_code || hit_chk || hit_se || hit_sw || hit_scan
                    || hit_led || hit_ist || hit_msk;

    // ==========================================================
    // Code words, kept readable at all times
    logic [31:0] heavy_fault_code_word;
    logic [31:0] light_fault_code_word;
    logic [31:0] code_rd;

    efa_word_reg #(
        .WIDTH (32)
    ) u_words (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (wr && hit_code),
        .wr_sel  (!hit_hc),
        .wr_data (pwdata),
        .rd_sel  (!hit_hc),
        .rd_data (code_rd),
        .word0   (heavy_fault_code_word),
        .word1   (light_fault_code_word)
    );

    // ==========================================================
    // Check requests and scan end
    logic heavy_check_request;
    logic light_check_request;
    logic scan_end_sw;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            heavy_check_request <= 1'b0;
            light_check_request <= 1'b0;
        end else if (wr && hit_chk) begin
            heavy_check_request <= pwdata[EFA_BIT_HEAVY_CHK];
            light_check_request <= pwdata[EFA_BIT_LIGHT_CHK];
        end
    end

    // Software may also end a scan; a write pulses it for one cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_end_sw <= 1'b0;
        end else begin
            scan_end_sw <= wr && hit_scan && pwdata[0];
        end
    end

    wire scan_done   = scan_end || scan_end_sw;
    // Any nonzero code counts as a fault of its class
    wire heavy_set   = |heavy_fault_code_word;                 // RULE_12
    wire light_set   = |light_fault_code_word;                 // RULE_12
    wire heavy_found = scan_done && heavy_check_request
                       && heavy_set;                           // RULE_02
    wire light_found = scan_done && light_check_request
                       && light_set;                           // RULE_08

    // ==========================================================
    // Heavy fault state: only a reset leaves it
    efa_state_t state;
    efa_state_t next_state;
    logic       annunciator_error_bit;
    logic       annunciator_warning_bit;

    always_comb begin
        next_state = state;
        case (state)
            EFA_RUN: begin
                if (heavy_found) begin
                    next_state = EFA_HALT;                     // RULE_01
                end
            end
            EFA_HALT: begin
                next_state = EFA_HALT;                         // RULE_06
            end
            default: begin
                next_state = EFA_HALT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= EFA_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            annunciator_error_bit <= 1'b0;
        end else if (heavy_found) begin
            annunciator_error_bit <= 1'b1;                     // RULE_03
        end
    end

    // Dropping the request wins: the warning follows the request bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            annunciator_warning_bit <= 1'b0;
        end else if (!light_check_request) begin
            annunciator_warning_bit <= 1'b0;                   // RULE_10
        end else if (light_found) begin
            annunciator_warning_bit <= 1'b1;                   // RULE_09
        end
    end

    // ==========================================================
    // Plant outputs
    wire heavy_on = state == EFA_HALT;
    assign halted      = heavy_on;                             // RULE_04
    assign outputs_off = heavy_on;                             // RULE_04
    assign leds.error_indicator         = heavy_on;            // RULE_05
    assign leds.supply_status_indicator = heavy_on
                                || annunciator_warning_bit;    // RULE_09
    assign leds.check_indicator         = heavy_on
                                || annunciator_warning_bit;    // RULE_09

    // ==========================================================
    // Interrupts: read clears, a new event in the same cycle wins
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    wire  [1:0] irq_event = {light_found && !annunciator_warning_bit,
                             heavy_found && !heavy_on};
    wire        ist_read  = rd && hit_ist;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= EFA_RST_BITS;
        end else begin
            irq_status <= (ist_read ? 2'h0 : irq_status) | irq_event;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask <= EFA_RST_BITS;
        end else if (wr && hit_msk) begin
            irq_mask <= pwdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // Read mux; code words come from the bank's registered port
    wire [31:0] rd_other =
        hit_chk ? {30'h0, light_check_request, heavy_check_request} :
        hit_se  ? {31'h0, annunciator_error_bit} :
        hit_sw  ? {31'h0, annunciator_warning_bit} :
        hit_led ? {29'h0, leds} :
        hit_ist ? {30'h0, irq_status} :
        hit_msk ? {30'h0, irq_mask} : 32'h0;

    // Code reads take one wait state so the bank register settles
    logic code_wait;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            code_wait <= 1'b0;
        end else begin
            code_wait <= acc && hit_code && !pwrite && !code_wait;
        end
    end

    assign pready  = !(acc && hit_code && !pwrite && !code_wait);
    assign prdata  = hit_code ? code_rd : rd_other;  // RULE_07 RULE_11
    assign pslverr = acc && !mapped;

    // ==========================================================
    // Checks
    property p_heavy_halts;
        @(posedge clk) disable iff (sys_rst)
        heavy_found |=> halted && outputs_off && leds.error_indicator;
    endproperty
    a_heavy_halts: assert property (p_heavy_halts) // RULE_04
        else $error("heavy fault did not halt");

    property p_err_bit;
        @(posedge clk) disable iff (sys_rst)
        heavy_found |=> annunciator_error_bit;
    endproperty
    a_err_bit: assert property (p_err_bit) // RULE_03
        else $error("error bit not set");

    property p_latched;
        @(posedge clk) disable iff (sys_rst)
        halted |=> halted && leds.error_indicator && leds.check_indicator;
    endproperty
    a_latched: assert property (p_latched) // RULE_06
        else $error("heavy fault released without reset");

    property p_leds_heavy;
        @(posedge clk) disable iff (sys_rst)
        leds.error_indicator |-> leds.supply_status_indicator
                                 && leds.check_indicator;
    endproperty
    a_leds_heavy: assert property (p_leds_heavy) // RULE_05
        else $error("heavy indicators incomplete");

    property p_no_check;
        @(posedge clk) disable iff (sys_rst)
        (scan_done && !heavy_check_request && !halted) |=> !halted;
    endproperty
    a_no_check: assert property (p_no_check) // RULE_02
        else $error("halted without check request");

    property p_zero_code;
        @(posedge clk) disable iff (sys_rst)
        (heavy_fault_code_word == 32'h0 && !halted) |=> !halted;
    endproperty
    a_zero_code: assert property (p_zero_code) // RULE_12
        else $error("zero code raised a fault");

    property p_warn_set;
        @(posedge clk) disable iff (sys_rst)
        light_found |=> annunciator_warning_bit
                        || !light_check_request;
    endproperty
    a_warn_set: assert property (p_warn_set) // RULE_08
        else $error("warning not raised");

    property p_warn_no_err;
        @(posedge clk) disable iff (sys_rst)
        (annunciator_warning_bit && !halted) |->
            !leds.error_indicator && leds.check_indicator;
    endproperty
    a_warn_no_err: assert property (p_warn_no_err) // RULE_09
        else $error("warning indicators wrong");

    property p_warn_clear;
        @(posedge clk) disable iff (sys_rst)
        $fell(light_check_request) |=> !annunciator_warning_bit;
    endproperty
    a_warn_clear: assert property (p_warn_clear) // RULE_10
        else $error("warning not cleared");

    property p_light_read;
        @(posedge clk) disable iff (sys_rst)
        (rd && hit_lc && pready) |-> prdata == light_fault_code_word;
    endproperty
    a_light_read: assert property (p_light_read) // RULE_11
        else $error("light code read wrong");

    property p_warn_only;
        @(posedge clk) disable iff (sys_rst)
        (light_found && !heavy_found && !halted) |=> !halted;
    endproperty
    a_warn_only: assert property (p_warn_only) // RULE_01
        else $error("light fault halted");

    property p_heavy_read;
        @(posedge clk) disable iff (sys_rst)
        (rd && hit_hc && pready) |-> prdata == heavy_fault_code_word;
    endproperty
    a_heavy_read: assert property (p_heavy_read) // RULE_07
        else $error("heavy code read wrong");

    // Evaluation happens only at a scan end, never in mid-scan
    property p_no_scan_halt;
        @(posedge clk) disable iff (sys_rst)
        (!scan_done && !halted) |=> !halted;
    endproperty
    a_no_scan_halt: assert property (p_no_scan_halt) // RULE_02
        else $error("halted outside scan end");

    property p_no_scan_warn;
        @(posedge clk) disable iff (sys_rst)
        (!scan_done && !annunciator_warning_bit) |=> !annunciator_warning_bit;
    endproperty
    a_no_scan_warn: assert property (p_no_scan_warn) // RULE_08
        else $error("warning raised outside scan end");

    property p_err_stays;
        @(posedge clk) disable iff (sys_rst)
        annunciator_error_bit |=> annunciator_error_bit;
    endproperty
    a_err_stays: assert property (p_err_stays) // RULE_06
        else $error("error bit dropped without reset");

    property p_warn_follow;
        @(posedge clk) disable iff (sys_rst)
        !light_check_request |=> !annunciator_warning_bit;
    endproperty
    a_warn_follow: assert property (p_warn_follow) // RULE_10
        else $error("warning kept without request");

    c_heavy: cover property (@(posedge clk) heavy_found);
    c_light: cover property (@(posedge clk) light_found);
    c_clear: cover property (@(posedge clk) $fell(annunciator_warning_bit));
    c_irq:   cover property (@(posedge clk) irq);
    c_sw:    cover property (@(posedge clk) scan_end_sw && heavy_found);
endmodule

/* test/efa_prog_model.sv */
// Model of the user sequence program: APB master plus scan pulse.
// Assumes the annunciator shares clk and answers with pready.
`timescale 1ns/1ns
module efa_prog_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Scan completion
    output logic             scan_end
);
    // ========
    // Last answer
    logic [31:0] rdata;
    logic        err;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        scan_end = 1'b0;
    end

    // ========
    // One APB transfer; pready, prdata and pslverr are taken at the
    // rising edge that completes it, before the slave's flops move
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep showing the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    // ========
    // End of program scan
    task automatic scan;
        @(posedge clk);
        scan_end <= 1'b1;
        @(posedge clk);
        scan_end <= 1'b0;
    endtask
endmodule

/* test/test_external_fault_annunciator.sv */
// Testbench for the external fault annunciator.
// Assumes efa_prog_model acts as program and bus master.
`timescale 1ns/1ns
module test_external_fault_annunciator
    import efa_pkg::*;
;
    // ========
    // Signals
    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scan_end;
    logic        outputs_off;
    logic        halted;
    logic        irq;
    efa_leds_t   leds;
    logic [31:0] hc;
    logic [31:0] lc;
    integer      seed;
    int          errors;
    int          cmp_count;
    int          cyc;

    efa_annunciator dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_end(scan_end),
        .outputs_off(outputs_off), .halted(halted), .leds(leds),
        .irq(irq));

    efa_prog_model prog_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_end(scan_end));

    // ========
    // Expectations and checks
    function automatic logic [5:0] exp_pins(input logic h, l, q);
        return {h, h, q, h, h | l, h | l};
    endfunction

    task automatic print_verdict;
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Levels settle an edge after their cause, so let one pass
    task automatic pins(input logic h, l, q);
        logic [5:0] g;
        @(posedge clk);
        @(negedge clk);
        g = {outputs_off, halted, irq, leds};
        cmp_count++;
        if (g !== exp_pins(h, l, q)) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g,
                     exp_pins(h, l, q));
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        prog_u.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        prog_u.xfer(1'b0, a, 32'h0);
        chk_w(prog_u.rdata, e);
    endtask

    // ========
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors++;
            print_verdict();
        end
    end

    // ========
    // Main sequence
    initial begin
        errors = 0;
        cmp_count = 0;
        seed = 22;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(EFA_OFF_SUM_ERR, 32'h0);
        rd(EFA_OFF_SUM_WARN, 32'h0);
        rd(EFA_OFF_INDICATORS, 32'h0);
        wr(8'h30, 32'h1);
        chk_w({31'h0, prog_u.err}, 32'h1);
        wr(EFA_OFF_SUM_ERR, 32'h1);
        rd(EFA_OFF_SUM_ERR, 32'h0);
        wr(EFA_OFF_IRQ_MASK, 32'h3);
        rd(EFA_OFF_IRQ_MASK, 32'h3);
        // Light words: a zero code first, then random codes
        for (int k = 0; k < 3; k++) begin
            lc = (k == 0) ? 32'h0 : $random(seed);
            wr(EFA_OFF_LIGHT_CODE, lc);
            wr(EFA_OFF_CHECK, 32'h2);
            pins(1'b0, 1'b0, 1'b0);
            prog_u.scan();
            pins(1'b0, lc != 0, lc != 0);
            rd(EFA_OFF_SUM_WARN, {31'h0, lc != 0});
            rd(EFA_OFF_LIGHT_ALIAS, lc);
            rd(EFA_OFF_IRQ_STATUS, {30'h0, lc != 0, 1'b0});
            wr(EFA_OFF_CHECK, 32'h0);
            pins(1'b0, 1'b0, 1'b0);
            rd(EFA_OFF_SUM_WARN, 32'h0);
        end
        // Heavy word: zero code, then a random nonzero code
        wr(EFA_OFF_HEAVY_CODE, 32'h0);
        wr(EFA_OFF_CHECK, 32'h1);
        prog_u.scan();
        pins(1'b0, 1'b0, 1'b0);
        hc = $random(seed) | 32'h1;
        wr(EFA_OFF_HEAVY_CODE, hc);
        pins(1'b0, 1'b0, 1'b0);
        // A set code with no request must not be evaluated
        wr(EFA_OFF_CHECK, 32'h0);
        prog_u.scan();
        pins(1'b0, 1'b0, 1'b0);
        wr(EFA_OFF_CHECK, 32'h1);
        prog_u.scan();
        pins(1'b1, 1'b0, 1'b1);
        rd(EFA_OFF_SUM_ERR, 32'h1);
        rd(EFA_OFF_HEAVY_CODE, hc);
        rd(EFA_OFF_INDICATORS, 32'h7);
        wr(EFA_OFF_HEAVY_CODE, 32'h0);
        wr(EFA_OFF_CHECK, 32'h0);
        prog_u.scan();
        rd(EFA_OFF_IRQ_STATUS, 32'h1);
        pins(1'b1, 1'b0, 1'b0);
        // Only a reset ends the halt; mask is back to zero after it
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        pins(1'b0, 1'b0, 1'b0);
        wr(EFA_OFF_HEAVY_CODE, hc);
        wr(EFA_OFF_CHECK, 32'h1);
        wr(EFA_OFF_SCAN_END, 32'h1);
        repeat (2) @(posedge clk);
        pins(1'b1, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
